// ### hdlc_rx_params.svh
// offsets, field positions, reset values and counts of the receive status block
`ifndef HDLC_RX_PARAMS_SVH
`define HDLC_RX_PARAMS_SVH

`define ADR_HIGH_FIRST   8'h50
`define ADR_HIGH_SECOND  8'h51
`define ADR_LOW_FIRST    8'h52
`define ADR_LOW_SECOND   8'h53
`define ADR_FRAME_STATUS 8'h65
`define ADR_COUNT_LOW    8'h66
`define ADR_COUNT_HIGH   8'h67
`define ADR_IRQ_STAT0    8'h68
`define ADR_IRQ_STAT1    8'h69
`define ADR_IRQ_MASK0    8'h6a
`define ADR_IRQ_MASK1    8'h6b
`define ADR_MODE_CTL     8'h6c
`define ADR_IRQ_CTL      8'h6d
`define ADR_GLOBAL_IRQ   8'h6e

`define RST_BYTE         8'h00
`define RST_MASK         8'hff

`define MODE_LSB         0
`define MODE_MSB         2
`define MODE_CHECK_BIT   3
`define MODE_MSG_BIT     4
`define MODE_FMT_LSB     5
`define MODE_FMT_MSB     6
`define IRQ_VIS_BIT      0
`define IRQ_SCI_BIT      1

`define MODE_TRANSP0     3'h0
`define MODE_ADDR8       3'h2
`define MODE_ADDR16      3'h3
`define FMT_F12          2'h0
`define FMT_ESF          2'h1
`define FMT_F72          2'h2

`define STAT0_MSG_END    7
`define STAT0_FRM_START  6
`define STAT0_SYNC_ERR   5
`define STAT0_MF_BEGIN   4
`define STAT0_SIG_CHG    3
`define STAT0_MF_CHECK   2
`define STAT0_DENSITY    1
`define STAT0_POOL_FULL  0
`define STAT1_TX_SIG     7
`define STAT1_OVERFLOW   6

`define BROADCAST_A      8'hfe
`define BROADCAST_B      8'hfc
`define CR_MASK          8'hfd
`define MAX_COUNT        12'hfff
`define POOL_LAST        5'h1f
`define SYNC_WIN_LAST    6'h1f
`define SYNC_ONES_LAST   4'h7
`define ZERO_RUN_MAX     5'h0f
`define DENS_WIN_LAST    8'hbf
`define DENS_MIN_ONES    5'h17
`define F72_SPAN_LAST    4'hb

`endif

// ### hdlc_rx_pkg.sv
// types shared by the receive status block and its surroundings
package hdlc_rx_pkg;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_byte_type;

  typedef struct packed {
    logic valid;
    logic byte_aligned;
    logic crc_ok;
    logic abort;
    logic bit_message;
  } frame_end_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fifo_wr_type;

  typedef struct packed {
    logic [7:0]  high_first;
    logic [7:0]  high_second;
    logic [7:0]  low_first;
    logic [7:0]  low_second;
    logic [7:0]  mask0;
    logic [7:0]  mask1;
    logic [7:0]  mode_ctl;
    logic [7:0]  irq_ctl;
    logic [7:0]  frame_status;
    logic [7:0]  count_low;
    logic [7:0]  count_high;
    logic [7:0]  stat0;
    logic [7:0]  stat1;
    logic [7:0]  rdata;
    logic        irq;
    fifo_wr_type fifo;
    logic [11:0] cnt;
    logic [4:0]  chunk;
    logic        ovf;
    logic [1:0]  ha;
    logic        ha_ok;
    logic        low_hit;
    logic        low_hit_ok;
    logic        pend;
    logic [7:0]  pend_stat;
    logic [5:0]  sync_win;
    logic [3:0]  sync_run;
    logic [4:0]  zero_run;
    logic [7:0]  dens_win;
    logic [4:0]  dens_ones;
    logic        ones_viol;
    logic        dens_r;
    logic [3:0]  f72_cnt;
  } state_type;

endpackage : hdlc_rx_pkg

// ### hdlc_rx_status.sv
// receive status byte, byte counts, address compare and interrupt groups 0 and 1
// Contract
// R1: status byte stored last in receive fifo
// R2: valid flag clear on non-octet frame length
// R3: two-byte addressing too-short lengths flagged invalid
// R4: one-byte addressing too-short lengths flagged invalid
// R5: overflow during frame sets status bit
// R6: check flag shows check sequence result
// R7: abort flag set for aborted frames
// R8: high byte compared to two registers, broadcast
// R9: high match code 00/01/10/11, first wins
// R10: type flag 1 hdlc, 0 bit message
// R11: low byte match flag first/second register
// R12: twelve-bit frame length, low bits fifo fill
// R13: host reads both counts after message end
// R14: reading a status group clears it
// R15: masked bits never reach output or summary
// R16: message end once status byte stored
// R17: pool full per 32 bytes mid-frame
// R18: frame start two bytes after address match
// R19: no eight ones in 32 bits flags
// R20: signaling change flagged only when synchronous
// R21: density violation on zeros or sparse ones
// R22: transmit signaling empty per multiframe/12 frames
// R23: summary holds one bit per group
// R24: event beats a clearing read
// R25: output follows any unmasked pending bit
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "hdlc_rx_params.svh"
`default_nettype none

module hdlc_rx_status #(
  parameter int SIG_W = 24
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output var  logic [7:0]                reg_rdata,
  // receive engine
  input  wire hdlc_rx_pkg::rx_byte_type   rx_byte,
  input  wire hdlc_rx_pkg::frame_end_type rx_end,
  input  wire logic                      fifo_overflow,
  input  wire logic                      msg_bit_valid,
  input  wire logic                      msg_bit,
  // framer
  input  wire logic                      line_bit_valid,
  input  wire logic                      line_bit,
  input  wire logic                      frame_sync,
  input  wire logic                      rx_multiframe_begin,
  input  wire logic                      multiframe_check_error,
  input  wire logic                      sig_update,
  input  wire logic [SIG_W-1:0]          sig_data,
  input  wire logic                      tx_frame_start,
  input  wire logic                      tx_multiframe_start,
  // fifo and interrupt
  output var  hdlc_rx_pkg::fifo_wr_type   fifo_wr,
  output var  logic                      irq
);

  if (SIG_W < 1 || SIG_W > 96) begin : g_bad_width
    $error("SIG_W out of range");
  end

  hdlc_rx_pkg::state_type s_r;
  hdlc_rx_pkg::state_type s_nxt;
  logic [SIG_W-1:0]       sig_prev_r;
  logic [SIG_W-1:0]       sig_prev_nxt;

  // first register compared without the c/r bit, so equal contents report it
  function automatic logic [2:0] high_code(input logic [7:0] b, input logic [7:0] r1, input logic [7:0] r2);
    if ((b & `CR_MASK) == (r1 & `CR_MASK))
      return {1'b1, 1'b1, b[1]};
    else if (b == r2)
      return 3'b100;
    else if (b == `BROADCAST_A || b == `BROADCAST_B)
      return 3'b101;
    else
      return 3'b000;
  endfunction : high_code

  function automatic logic [1:0] low_code(input logic [7:0] b, input logic [7:0] r1, input logic [7:0] r2);
    if (b == r1)
      return 2'b11;
    else if (b == r2)
      return 2'b10;
    else
      return 2'b00;
  endfunction : low_code

  // sets win over a same-cycle clearing read
  function automatic logic [7:0] stat_update(input logic [7:0] cur, input logic clr,
                                             input logic [7:0] ev, input logic [7:0] mask,
                                             input logic vis);
    return (clr ? 8'h00 : cur) | (ev & (~mask | {8{vis}}));
  endfunction : stat_update

  always_comb begin
    logic [2:0]  mode;
    logic [1:0]  addr_len;
    logic [7:0]  ev0;
    logic [7:0]  ev1;
    logic [11:0] cnt_new;
    logic [2:0]  hc;
    logic [1:0]  lc;
    logic        too_short;
    logic        ovf_eff;
    logic        addr_ok;
    logic [7:0]  status;
    logic        dens_now;
    logic [7:0]  pending;
    mode     = s_r.mode_ctl[`MODE_MSB:`MODE_LSB];
    addr_len = (mode == `MODE_ADDR16) ? 2'd2 : (mode == `MODE_ADDR8) ? 2'd1 : 2'd0;
    ev0      = 8'h00;
    ev1      = 8'h00;
    cnt_new  = s_r.cnt;
    hc       = 3'b000;
    lc       = 2'b00;
    too_short = 1'b0;
    status   = 8'h00;
    ovf_eff  = 1'b0;
    addr_ok  = 1'b0;
    dens_now = 1'b0;
    pending  = 8'h00;
    s_nxt    = s_r;
    s_nxt.fifo.valid = 1'b0;
    sig_prev_nxt = sig_prev_r;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `ADR_HIGH_FIRST:  s_nxt.high_first  = reg_wdata;
        `ADR_HIGH_SECOND: s_nxt.high_second = reg_wdata;
        `ADR_LOW_FIRST:   s_nxt.low_first   = reg_wdata;
        `ADR_LOW_SECOND:  s_nxt.low_second  = reg_wdata;
        `ADR_IRQ_MASK0:   s_nxt.mask0       = reg_wdata;
        `ADR_IRQ_MASK1:   s_nxt.mask1       = reg_wdata;
        `ADR_MODE_CTL:    s_nxt.mode_ctl    = reg_wdata;
        `ADR_IRQ_CTL:     s_nxt.irq_ctl     = reg_wdata;
        default:          s_nxt.mode_ctl    = s_r.mode_ctl;
      endcase
    end

    // pending status goes out in the idle cycle after the last byte
    if (s_r.pend) begin
      s_nxt.fifo.valid = 1'b1;  // [R1]
      s_nxt.fifo.data  = s_r.pend_stat;
      s_nxt.pend       = 1'b0;
      ev0[`STAT0_MSG_END] = 1'b1;  // [R16]
    end

    if (fifo_overflow) begin
      s_nxt.ovf = 1'b1;  // [R5]
      ev1[`STAT1_OVERFLOW] = 1'b1;
    end

    // data bytes, counting and address capture
    if (rx_byte.valid) begin
      cnt_new = (s_r.cnt == `MAX_COUNT) ? s_r.cnt : s_r.cnt + 12'h001;  // [R12]
      s_nxt.cnt   = cnt_new;
      s_nxt.chunk = s_r.chunk + 5'h01;
      s_nxt.fifo.valid = 1'b1;
      s_nxt.fifo.data  = rx_byte.data;
      hc = high_code(rx_byte.data, s_r.high_first, s_r.high_second);  // [R8]
      lc = low_code(rx_byte.data, s_r.low_first, s_r.low_second);
      if (mode == `MODE_ADDR16 && s_r.cnt == 12'h000) begin
        s_nxt.ha    = hc[1:0];  // [R9]
        s_nxt.ha_ok = hc[2];
      end
      if ((mode == `MODE_ADDR16 && s_r.cnt == 12'h001) || (mode == `MODE_ADDR8 && s_r.cnt == 12'h000)) begin
        s_nxt.low_hit    = lc[0];  // [R11]
        s_nxt.low_hit_ok = lc[1];
      end
      addr_ok = (addr_len == 2'd0) || (s_nxt.low_hit_ok && (addr_len == 2'd1 || s_nxt.ha_ok));
      if (cnt_new == {10'h000, addr_len} + 12'h002 && addr_ok) begin
        ev0[`STAT0_FRM_START] = 1'b1;  // [R18]
        s_nxt.frame_status[3:1] = {s_nxt.ha, 1'b1};
        s_nxt.frame_status[0]   = s_nxt.low_hit;
      end
      if (s_r.chunk == `POOL_LAST && !rx_end.valid)
        ev0[`STAT0_POOL_FULL] = 1'b1;  // [R17]
    end

    // frame end: build status byte and latch counts
    if (rx_end.valid) begin
      // byte count here excludes the status byte
      if (mode == `MODE_ADDR16)
        too_short = s_r.mode_ctl[`MODE_CHECK_BIT] ? (cnt_new == 12'h003 || cnt_new == 12'h004)
                                                  : (cnt_new == 12'h004);  // [R3]
      else if (mode == `MODE_ADDR8)
        too_short = s_r.mode_ctl[`MODE_CHECK_BIT] ? (cnt_new == 12'h002 || cnt_new == 12'h003)
                                                  : (cnt_new == 12'h003);  // [R4]
      ovf_eff = s_r.ovf | fifo_overflow;
      if (rx_end.bit_message)
        status = 8'h00;  // [R10]
      else
        status = {rx_end.byte_aligned & ~too_short,  // [R2]
                  ovf_eff,                           // [R5]
                  rx_end.crc_ok,                     // [R6]
                  rx_end.abort,                      // [R7]
                  s_nxt.ha,
                  1'b1,                              // [R10]
                  s_nxt.low_hit};
      s_nxt.frame_status = status;
      s_nxt.count_low    = cnt_new[7:0];  // [R12]
      s_nxt.count_high   = {4'h0, cnt_new[11:8]};
      if (rx_byte.valid) begin
        s_nxt.pend      = 1'b1;
        s_nxt.pend_stat = status;
      end else begin
        s_nxt.fifo.valid = 1'b1;  // [R1]
        s_nxt.fifo.data  = status;
        ev0[`STAT0_MSG_END] = 1'b1;  // [R16]
      end
      s_nxt.cnt   = 12'h000;
      s_nxt.chunk = 5'h00;
      s_nxt.ovf   = 1'b0;
      s_nxt.ha_ok = 1'b0;
      s_nxt.low_hit_ok = 1'b0;
    end

    // bit-message sync search
    if (!s_r.mode_ctl[`MODE_MSG_BIT]) begin
      s_nxt.sync_win = 6'h00;
      s_nxt.sync_run = 4'h0;
    end else if (msg_bit_valid) begin
      if (msg_bit && s_r.sync_run == `SYNC_ONES_LAST) begin
        s_nxt.sync_win = 6'h00;
        s_nxt.sync_run = 4'h0;
      end else begin
        s_nxt.sync_run = msg_bit ? s_r.sync_run + 4'h1 : 4'h0;
        s_nxt.sync_win = (s_r.sync_win == `SYNC_WIN_LAST) ? 6'h00 : s_r.sync_win + 6'h01;
        if (s_r.sync_win == `SYNC_WIN_LAST)
          ev0[`STAT0_SYNC_ERR] = 1'b1;  // [R19]
      end
    end

    // pulse density over fixed windows; a trade against a sliding window
    if (line_bit_valid) begin
      if (line_bit)
        s_nxt.zero_run = 5'h00;
      else if (s_r.zero_run <= `ZERO_RUN_MAX)
        s_nxt.zero_run = s_r.zero_run + 5'h01;
      if (s_r.dens_win == `DENS_WIN_LAST) begin
        s_nxt.dens_win  = 8'h00;
        s_nxt.dens_ones = 5'h00;
        s_nxt.ones_viol = (s_r.dens_ones + {4'h0, line_bit}) < `DENS_MIN_ONES;
      end else begin
        s_nxt.dens_win = s_r.dens_win + 8'h01;
        if (line_bit && s_r.dens_ones < `DENS_MIN_ONES)
          s_nxt.dens_ones = s_r.dens_ones + 5'h01;
      end
    end
    dens_now = (s_nxt.zero_run > `ZERO_RUN_MAX) | s_nxt.ones_viol;
    s_nxt.dens_r = dens_now;
    if (s_r.irq_ctl[`IRQ_SCI_BIT] ? (dens_now != s_r.dens_r) : (dens_now && !s_r.dens_r))
      ev0[`STAT0_DENSITY] = 1'b1;  // [R21]

    // signaling change, only while synchronous
    if (sig_update) begin
      sig_prev_nxt = sig_data;
      if (frame_sync && sig_data != sig_prev_r)
        ev0[`STAT0_SIG_CHG] = 1'b1;  // [R20]
    end
    ev0[`STAT0_MF_BEGIN] = rx_multiframe_begin;
    ev0[`STAT0_MF_CHECK] = multiframe_check_error;

    // transmit robbed-bit request
    if (tx_multiframe_start) begin
      s_nxt.f72_cnt = 4'h0;
      ev1[`STAT1_TX_SIG] = 1'b1;  // [R22]
    end else if (tx_frame_start) begin
      s_nxt.f72_cnt = (s_r.f72_cnt == `F72_SPAN_LAST) ? 4'h0 : s_r.f72_cnt + 4'h1;
      if (s_r.mode_ctl[`MODE_FMT_MSB:`MODE_FMT_LSB] == `FMT_F72 && s_r.f72_cnt == `F72_SPAN_LAST)
        ev1[`STAT1_TX_SIG] = 1'b1;  // [R22]
    end

    // status groups
    s_nxt.stat0 = stat_update(s_r.stat0, reg_rd && reg_addr == `ADR_IRQ_STAT0, ev0,
                              s_r.mask0, s_r.irq_ctl[`IRQ_VIS_BIT]);  // [R14] [R24] [R15]
    s_nxt.stat1 = stat_update(s_r.stat1, reg_rd && reg_addr == `ADR_IRQ_STAT1, ev1,
                              s_r.mask1, s_r.irq_ctl[`IRQ_VIS_BIT]);  // [R14] [R24] [R15]
    pending = {6'h00, |(s_nxt.stat1 & ~s_r.mask1), |(s_nxt.stat0 & ~s_r.mask0)};  // [R23] [R15]
    s_nxt.irq = |pending;  // [R25]

    // read data one cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `ADR_HIGH_FIRST:   s_nxt.rdata = s_r.high_first;
        `ADR_HIGH_SECOND:  s_nxt.rdata = s_r.high_second;
        `ADR_LOW_FIRST:    s_nxt.rdata = s_r.low_first;
        `ADR_LOW_SECOND:   s_nxt.rdata = s_r.low_second;
        `ADR_FRAME_STATUS: s_nxt.rdata = s_r.frame_status;
        `ADR_COUNT_LOW:    s_nxt.rdata = s_r.count_low;  // [R13]
        `ADR_COUNT_HIGH:   s_nxt.rdata = s_r.count_high;
        `ADR_IRQ_STAT0:    s_nxt.rdata = s_r.stat0;
        `ADR_IRQ_STAT1:    s_nxt.rdata = s_r.stat1;
        `ADR_IRQ_MASK0:    s_nxt.rdata = s_r.mask0;
        `ADR_IRQ_MASK1:    s_nxt.rdata = s_r.mask1;
        `ADR_MODE_CTL:     s_nxt.rdata = s_r.mode_ctl;
        `ADR_IRQ_CTL:      s_nxt.rdata = s_r.irq_ctl;
        `ADR_GLOBAL_IRQ:   s_nxt.rdata = {6'h00, |(s_r.stat1 & ~s_r.mask1), |(s_r.stat0 & ~s_r.mask0)};
        default:           s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.mask0    <= `RST_MASK;
      s_r.mask1    <= `RST_MASK;
      s_r.mode_ctl <= `RST_BYTE;
      s_r.irq_ctl  <= `RST_BYTE;
      sig_prev_r   <= '0;
    end else begin
      s_r          <= s_nxt;
      sig_prev_r   <= sig_prev_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign fifo_wr   = s_r.fifo;
  assign irq       = s_r.irq;

endmodule : hdlc_rx_status

`default_nettype wire

// ### hdlc_station.sv
// remote sending station model: bytes of one frame, end marker after the last byte or, with gap 3, on it
`timescale 1ns/100ps
`default_nettype none

module hdlc_station (
  // clock
  input  wire logic                       clk,
  // frame request
  input  wire logic                       go,
  input  wire logic [11:0]                len,
  input  wire logic [15:0]                head,
  input  wire hdlc_rx_pkg::frame_end_type tail,
  input  wire logic [1:0]                 gap,
  // line side
  output var  hdlc_rx_pkg::rx_byte_type   rx_byte,
  output var  hdlc_rx_pkg::frame_end_type rx_end,
  output var  logic                       busy
);
  // gap 3: bytes back to back, end marker rides on the last byte
  initial begin
    rx_byte = '0;
    rx_end  = '0;
    busy    = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < len; i++) begin
          rx_byte.valid <= 1'b1;
          rx_byte.data  <= (i == 0) ? head[15:8] : (i == 1) ? head[7:0] : 8'h55;
          if (gap == 2'd3 && i == len - 1)
            rx_end <= tail;
          @(posedge clk);
          // released data must not look like the last byte
          if (gap % 3 != 0 || i == len - 1) begin
            rx_byte.valid <= 1'b0;
            rx_byte.data  <= ~rx_byte.data;
          end
          repeat (gap % 3) @(posedge clk);
        end
        if (gap != 2'd3) begin
          rx_end <= tail;
          @(posedge clk);
        end
        rx_end <= '0;
        busy   <= 1'b0;
      end
    end
  end
endmodule : hdlc_station

`default_nettype wire

// ### hdlc_rx_status_assertions.sv
// concurrent checks on the frame path and read port of the receive status block
`timescale 1ns/100ps
`default_nettype none

module hdlc_rx_status_checker #(
  parameter int SIG_W = 24
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // watched ports
  input  wire logic                       reg_rd,
  input  wire logic [7:0]                 reg_rdata,
  input  wire hdlc_rx_pkg::rx_byte_type   rx_byte,
  input  wire hdlc_rx_pkg::frame_end_type rx_end,
  input  wire hdlc_rx_pkg::fifo_wr_type   fifo_wr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_end_alone;
    rx_end.valid && !rx_byte.valid;
  endsequence
  sequence s_end_hdlc;
    s_end_alone ##0 !rx_end.bit_message;
  endsequence

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_byte_forward: assert property (rx_byte.valid |=> fifo_wr.valid && fifo_wr.data == $past(rx_byte.data))
    else $error("byte not written to fifo");
  a_status_last: assert property (s_end_alone |=> fifo_wr.valid)
    else $error("status byte missing");
  a_crc_bit: assert property (s_end_hdlc |=> fifo_wr.data[5] == $past(rx_end.crc_ok))
    else $error("check flag wrong");
  a_abort_bit: assert property (s_end_hdlc |=> fifo_wr.data[4] == $past(rx_end.abort))
    else $error("abort flag wrong");
  a_type_bit: assert property (s_end_alone |=> fifo_wr.data[1] == !$past(rx_end.bit_message))
    else $error("frame type flag wrong");
  a_msg_zero: assert property (s_end_alone ##0 rx_end.bit_message |=> fifo_wr.data == 8'h00)
    else $error("bit message status not zero");
  a_odd_invalid: assert property (s_end_hdlc ##0 !rx_end.byte_aligned |=> !fifo_wr.data[7])
    else $error("odd length frame marked valid");
endmodule : hdlc_rx_status_checker

bind hdlc_rx_status hdlc_rx_status_checker #(.SIG_W(SIG_W)) chk_i (
  .clk       (clk),
  .rst_n     (rst_n),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .rx_byte   (rx_byte),
  .rx_end    (rx_end),
  .fifo_wr   (fifo_wr)
);

`default_nettype wire

// ### tb.sv
// self-checking bench for the receive status block
`timescale 1ns/100ps
`include "hdlc_rx_params.svh"
`default_nettype none

module tb;
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  len;
    logic [15:0] head;
    logic [4:0]  tail;
    logic [7:0]  msk;
    logic [7:0]  exp;
  } row_type;
  // tail: valid, aligned, check ok, abort, bit message
  localparam row_type rows [15] = '{
    '{8'h03, 8'd6, 16'h4021, 5'h1c, 8'hff, 8'hab}, '{8'h03, 8'd6, 16'h4221, 5'h1c, 8'hff, 8'haf},
    '{8'h03, 8'd6, 16'h8021, 5'h1c, 8'hff, 8'ha3}, '{8'h03, 8'd6, 16'hfe21, 5'h1c, 8'hff, 8'ha7},
    '{8'h03, 8'd6, 16'hfc23, 5'h1c, 8'hff, 8'ha6}, '{8'h03, 8'd6, 16'h4021, 5'h18, 8'hff, 8'h8b},
    '{8'h03, 8'd6, 16'h4021, 5'h1e, 8'h7f, 8'h3b}, '{8'h03, 8'd6, 16'h4021, 5'h14, 8'hff, 8'h2b},
    '{8'h03, 8'd4, 16'h4021, 5'h1c, 8'hff, 8'h2b}, '{8'h03, 8'd5, 16'h4021, 5'h1c, 8'hff, 8'hab},
    '{8'h0b, 8'd3, 16'h4021, 5'h1c, 8'hff, 8'h2b}, '{8'h02, 8'd3, 16'h2100, 5'h1c, 8'hf3, 8'h23},
    '{8'h0a, 8'd2, 16'h2100, 5'h1c, 8'hf3, 8'h23}, '{8'h02, 8'd4, 16'h2100, 5'h1c, 8'hf3, 8'ha3},
    '{8'h03, 8'd6, 16'h4021, 5'h1d, 8'hff, 8'h00}};

  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, last_wr = 8'h00;
  logic fifo_overflow = 1'b0, msg_bit_valid = 1'b0, line_bit_valid = 1'b0, frame_sync = 1'b0;
  logic msg_bit = 1'b0, line_bit = 1'b0;
  logic rx_multiframe_begin = 1'b0, multiframe_check_error = 1'b0, sig_update = 1'b0;
  logic tx_frame_start = 1'b0, tx_multiframe_start = 1'b0, irq, busy;
  logic [23:0] sig_data = 24'h000000;
  logic [11:0] len = 12'h000;
  logic [15:0] head = 16'h0000;
  logic [1:0]  gap = 2'd0;
  hdlc_rx_pkg::frame_end_type tail = '0;
  hdlc_rx_pkg::rx_byte_type   rx_byte;
  hdlc_rx_pkg::frame_end_type rx_end;
  hdlc_rx_pkg::fifo_wr_type   fifo_wr;
  int fail_count = 0, cmp_count = 0;

  hdlc_station peer (.clk(clk), .go(go), .len(len), .head(head), .tail(tail), .gap(gap),
                     .rx_byte(rx_byte), .rx_end(rx_end), .busy(busy));
  hdlc_rx_status uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte(rx_byte), .rx_end(rx_end),
    .fifo_overflow(fifo_overflow), .msg_bit_valid(msg_bit_valid), .msg_bit(msg_bit),
    .line_bit_valid(line_bit_valid), .line_bit(line_bit), .frame_sync(frame_sync),
    .rx_multiframe_begin(rx_multiframe_begin), .multiframe_check_error(multiframe_check_error),
    .sig_update(sig_update), .sig_data(sig_data), .tx_frame_start(tx_frame_start),
    .tx_multiframe_start(tx_multiframe_start), .fifo_wr(fifo_wr), .irq(irq));

  always #5 clk = ~clk;
  always @(posedge clk) if (fifo_wr.valid) last_wr <= fifo_wr.data;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_irq(input logic e);
    cmp_count++;
    if (irq !== e) begin
      fail_count++;
      $display("[ERR] irq expected %b seen %b", e, irq);
    end
  endtask : chk_irq

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // ev raises a multiframe begin in the very cycle of the read
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff, input logic ev = 1'b0);
    @(posedge clk);
    reg_addr            <= a;
    reg_rd              <= 1'b1;
    rx_multiframe_begin <= ev;
    @(posedge clk);
    reg_rd              <= 1'b0;
    rx_multiframe_begin <= 1'b0;
    @(negedge clk);
    chk(nm, e, reg_rdata & m);
  endtask : rc

  // one-cycle pulse on signaling update, check error, tx multiframe, tx frame
  task automatic strobe(input logic [3:0] s);
    @(posedge clk);
    {sig_update, multiframe_check_error, tx_multiframe_start, tx_frame_start} <= s;
    @(posedge clk);
    {sig_update, multiframe_check_error, tx_multiframe_start, tx_frame_start} <= 4'h0;
  endtask : strobe

  task automatic send(input logic [11:0] n, input logic [15:0] h, input logic [4:0] t,
                      input logic ov, input logic [1:0] g);
    int k;
    @(posedge clk);
    len  <= n;
    head <= h;
    tail <= t;
    gap  <= g;
    go   <= 1'b1;
    @(posedge clk);
    go            <= 1'b0;
    fifo_overflow <= ov;
    @(posedge clk);
    fifo_overflow <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (busy && k < 5000);
    if (k >= 5000) begin
      fail_count++;
      close_out();
    end
    // a status byte held behind its last byte lands a cycle later
    repeat (2) @(negedge clk);
  endtask : send

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rc("mask0", `ADR_IRQ_MASK0, 8'hff);
    rc("stat0", `ADR_IRQ_STAT0, 8'h00);
    rc("global", `ADR_GLOBAL_IRQ, 8'h00);
    rc("unmapped", 8'h10, 8'h00);
    wr(`ADR_COUNT_LOW, 8'h5a);
    rc("count ro", `ADR_COUNT_LOW, 8'h00);
    $display("test reset done");
    wr(`ADR_HIGH_FIRST, 8'h40);
    wr(`ADR_HIGH_SECOND, 8'h80);
    wr(`ADR_LOW_FIRST, 8'h21);
    wr(`ADR_LOW_SECOND, 8'h23);
    wr(`ADR_IRQ_MASK0, 8'h00);
    foreach (rows[i]) begin
      wr(`ADR_MODE_CTL, rows[i].mode);
      send({4'h0, rows[i].len}, rows[i].head, rows[i].tail, 1'b0, 2'(i % 3));
      chk("status", rows[i].exp, last_wr & rows[i].msk);
      chk_irq(1'b1);
      rc("count low", `ADR_COUNT_LOW, rows[i].len);
      rc("count high", `ADR_COUNT_HIGH, 8'h00, 8'h0f);
      rc("msg end", `ADR_IRQ_STAT0, 8'h80, 8'h81);
      rc("cleared", `ADR_IRQ_STAT0, 8'h00);
      chk_irq(1'b0);
      $display("test row %0d done", i);
    end
    wr(`ADR_MODE_CTL, 8'h03);
    wr(`ADR_IRQ_MASK1, 8'hbf);
    send(12'd40, 16'h4021, 5'h1c, 1'b1, 2'd0);
    chk("ovf status", 8'heb, last_wr);
    rc("count low", `ADR_COUNT_LOW, 8'h28);
    rc("pool", `ADR_IRQ_STAT0, 8'hc1, 8'hc1);
    rc("ovf irq", `ADR_IRQ_STAT1, 8'h40);
    $display("test long frame done");
    send(12'd6, 16'h4021, 5'h1c, 1'b0, 2'd3);
    chk("joined status", 8'hab, last_wr);
    rc("joined count", `ADR_COUNT_LOW, 8'h06);
    rc("joined end", `ADR_IRQ_STAT0, 8'h80, 8'h80);
    $display("test joined end done");
    rc("race", `ADR_IRQ_STAT0, 8'h00, 8'hff, 1'b1);
    rc("kept", `ADR_IRQ_STAT0, 8'h10);
    $display("test read race done");
    wr(`ADR_IRQ_CTL, 8'h01);
    wr(`ADR_IRQ_MASK0, 8'h04);
    strobe(4'b0100);
    @(negedge clk);
    chk_irq(1'b0);
    rc("global", `ADR_GLOBAL_IRQ, 8'h00);
    rc("visible", `ADR_IRQ_STAT0, 8'h04);
    wr(`ADR_IRQ_MASK0, 8'h00);
    wr(`ADR_IRQ_CTL, 8'h00);
    $display("test masked done");
    sig_data <= 24'h000001;
    strobe(4'b1000);
    rc("sig async", `ADR_IRQ_STAT0, 8'h00);
    frame_sync <= 1'b1;
    sig_data   <= 24'h000002;
    strobe(4'b1000);
    rc("sig sync", `ADR_IRQ_STAT0, 8'h08);
    $display("test signaling done");
    wr(`ADR_MODE_CTL, 8'h10);
    @(posedge clk);
    {msg_bit_valid, line_bit_valid} <= 2'b11;
    repeat (40) @(posedge clk);
    {msg_bit_valid, line_bit_valid} <= 2'b00;
    rc("global", `ADR_GLOBAL_IRQ, 8'h01);
    rc("sync dens", `ADR_IRQ_STAT0, 8'h22);
    wr(`ADR_IRQ_CTL, 8'h02);
    @(posedge clk);
    {msg_bit_valid, line_bit_valid, msg_bit, line_bit} <= 4'hf;
    repeat (40) @(posedge clk);
    {msg_bit_valid, line_bit_valid, msg_bit, line_bit} <= 4'h0;
    rc("ones", `ADR_IRQ_STAT0, 8'h02);
    $display("test line checks done");
    wr(`ADR_IRQ_MASK1, 8'h7f);
    strobe(4'b0001);
    rc("tx frame", `ADR_IRQ_STAT1, 8'h00);
    strobe(4'b0011);
    rc("tx multi", `ADR_IRQ_STAT1, 8'h80);
    wr(`ADR_MODE_CTL, 8'h40);
    repeat (11) strobe(4'b0001);
    rc("f72 early", `ADR_IRQ_STAT1, 8'h00);
    strobe(4'b0001);
    rc("f72 twelfth", `ADR_IRQ_STAT1, 8'h80);
    $display("test transmit done");
    close_out();
  end
endmodule : tb

`default_nettype wire
